// [design/isp_consts.vh]
`ifndef ISP_CONSTS_VH
`define ISP_CONSTS_VH

// Clock rate and self-timed write durations
`define ISP_CLK_KHZ                  100000
`define ISP_FLASH_PAGE_WAIT_TIME_MS  4.5
`define ISP_EEPROM_BYTE_WAIT_TIME_MS 9.0
`define ISP_CHIP_ERASE_WAIT_TIME_MS  9.0
`define ISP_BUSY_W                   20

// Busy spans in cycles of the 100 MHz clock (wait time times clock rate)
`define ISP_FLASH_WAIT_CYC  20'd450000
`define ISP_EEPROM_WAIT_CYC 20'd900000
`define ISP_ERASE_WAIT_CYC  20'd900000

// First instruction byte codes
`define ISP_B1_SPECIAL  8'hac
`define ISP_B1_RD_FLASH 8'h20
`define ISP_B1_LD_PAGE  8'h40
`define ISP_B1_WR_PAGE  8'h4c
`define ISP_B1_RD_EE    8'ha0
`define ISP_B1_WR_EE    8'hc0
`define ISP_B1_RD_LOCK  8'h58
`define ISP_B1_RD_FUSE  8'h50
`define ISP_H_BIT       3

// Second instruction byte codes
`define ISP_B2_PROG_EN    8'h53
`define ISP_B2_ERASE      3'h4
`define ISP_B2_WR_LOCK    3'h7
`define ISP_B2_WR_FUSE_LO 8'ha0
`define ISP_B2_WR_FUSE_HI 8'ha8
`define ISP_B2_RD_ZERO    8'h00
`define ISP_B2_RD_FUSE_HI 8'h08

// Nonvolatile bit reset values (erased state)
`define ISP_LOCK_W      6
`define ISP_LOCK_RST    6'h3f
`define ISP_FUSE_LO_RST 8'hff
`define ISP_FUSE_HI_RST 8'hff
`define ISP_ERASED_BYTE 8'hff

// Memory command word layout and operations
`define ISP_CMD_W        25
`define ISP_CMD_OP_LSB   23
`define ISP_CMD_HI_BIT   22
`define ISP_CMD_ADDR_LSB 8
`define ISP_FADDR_W      14
`define ISP_EADDR_W      10
`define ISP_PAGE_LSB     6
`define ISP_OP_LOAD      2'h0
`define ISP_OP_WR_PAGE   2'h1
`define ISP_OP_WR_EE     2'h2
`define ISP_OP_ERASE     2'h3
`define ISP_RD_FLASH     1'b0
`define ISP_RD_EE        1'b1

`endif

// [design/isp_pin_sync.v]
`timescale 1ns/100ps
`default_nettype none

module isp_pin_sync #(
	parameter       W       = 3,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	// Clock and reset
	input  wire         clk,
	input  wire         rst_n,
	input  wire         clk_en,
	// Raw pins and filtered levels
	input  wire [W-1:0] pin_in,
	output reg  [W-1:0] level_q
);

	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;

	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			// Three stages; level moves once stages two and three agree
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					s1_q[i]    <= RST_VAL[i];
					s2_q[i]    <= RST_VAL[i];
					s3_q[i]    <= RST_VAL[i];
					level_q[i] <= RST_VAL[i];
				end else if (clk_en) begin
					s1_q[i] <= pin_in[i];
					s2_q[i] <= s1_q[i];
					s3_q[i] <= s2_q[i];
					if (s2_q[i] == s3_q[i]) begin
						level_q[i] <= s3_q[i];
					end
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// [design/isp_buf2.v]
`timescale 1ns/100ps
`default_nettype none

module isp_buf2 #(
	parameter W = 25
) (
	// Clock and reset
	input  wire         clk,
	input  wire         rst_n,
	input  wire         clk_en,
	// Filling side
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	// Draining side
	output reg          out_valid,
	input  wire         out_ready,
	output reg  [W-1:0] out_data
);

	reg [W-1:0] d1_q;
	reg         v1_q;
	wire        push;
	wire        pop;

	// Full only when the second slot holds a word
	assign in_ready = ~v1_q;
	assign push     = in_valid & ~v1_q;
	assign pop      = out_valid & out_ready;

	// Head slot feeds the output, second slot backs it up
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_data  <= {W{1'b0}};
			d1_q      <= {W{1'b0}};
			v1_q      <= 1'b0;
		end else if (clk_en) begin
			if (pop) begin
				out_data  <= v1_q ? d1_q : in_data;
				out_valid <= v1_q | push;
				v1_q      <= 1'b0;
			end else if (push) begin
				if (!out_valid) begin
					out_data  <= in_data;
					out_valid <= 1'b1;
				end else begin
					d1_q <= in_data;
					v1_q <= 1'b1;
				end
			end
		end
	end

endmodule

`default_nettype wire

// [design/isp_port.v]
// Operation
// - Chip erase leaves every flash and EEPROM location at all ones.
// - Input sampled on rising serial clock, output shifted on falling.
// - In sync, byte two of enable echoes during byte three.
// - Page buffer loaded bytewise by six address bits, low byte first.
// - Write page commits buffer to the page in the eight upper bits.
// - EEPROM write self-timed with auto erase; 9.0 ms wait.
// - Reads answer in byte four; opcode bit picks flash high/low.
// - Reads inside a page being written return all ones.
// - Read of EEPROM byte being written returns all ones.
// - Enable decoded from bytes one and two; accepted after reset low.
// - Chip erase decoded from second byte 100x; 9.0 ms wait.
// - EEPROM read and write opcodes; ten-bit address; data in byte four.
// - Lock write and read encodings; six data bits; zero programmed.
// - Fuse low and high write and read encodings; zero programmed.
// - Interface only active while the reset pin is held low.
// - Lock bits return unprogrammed only through chip erase.
`timescale 1ns/100ps
`default_nettype none
`include "isp_consts.vh"

module isp_port #(
	parameter [`ISP_BUSY_W-1:0] FLASH_WAIT_CYC  = `ISP_FLASH_WAIT_CYC,
	parameter [`ISP_BUSY_W-1:0] EEPROM_WAIT_CYC = `ISP_EEPROM_WAIT_CYC,
	parameter [`ISP_BUSY_W-1:0] ERASE_WAIT_CYC  = `ISP_ERASE_WAIT_CYC
) (
	// Clock, reset, enable
	input  wire                    ref_clk,
	input  wire                    rst_n,
	input  wire                    clk_en,
	// Programming pins
	input  wire                    reset_pin_n,
	input  wire                    sck_pin,
	input  wire                    mosi_pin,
	output reg                     miso_o,
	output reg                     miso_oe,
	// Memory command stream
	output wire                    nvm_cmd_valid,
	input  wire                    nvm_cmd_ready,
	output wire [1:0]              nvm_cmd_op,
	output wire                    nvm_cmd_hi,
	output wire [`ISP_FADDR_W-1:0] nvm_cmd_addr,
	output wire [7:0]              nvm_cmd_data,
	// Memory read port, answer one cycle after request
	output reg                     nvm_rd_req,
	output reg                     nvm_rd_space,
	output reg                     nvm_rd_hi,
	output reg  [`ISP_FADDR_W-1:0] nvm_rd_addr,
	input  wire [7:0]              nvm_rd_data,
	// Status and nonvolatile bits
	output reg                     prog_enabled,
	output reg                     isp_busy,
	output reg                     cmd_refused,
	output reg  [`ISP_LOCK_W-1:0]  lock_bits,
	output reg  [7:0]              fuse_low,
	output reg  [7:0]              fuse_high,
	output wire [3:0]              clock_source_select_fuses
);

	// Filtered pins and edges
	wire [2:0] pin_lvl;
	reg        sck_prev_q;
	wire       sess;
	wire       sck_rise;
	wire       sck_fall;
	// Frame state
	reg  [4:0]  cnt_q;
	reg  [7:0]  rx_q;
	reg  [7:0]  b1_q;
	reg  [7:0]  b2_q;
	reg  [7:0]  b3_q;
	reg  [7:0]  tx_q;
	wire [7:0]  rx_d;
	wire        byte_done;
	wire        frame_done;
	// Busy tracking and read override
	reg  [`ISP_BUSY_W-1:0]  busy_cnt_q;
	reg  [1:0]              busy_op_q;
	reg  [`ISP_FADDR_W-1:0] busy_addr_q;
	reg                     rd_wait_q;
	reg                     rd_ff_q;
	// Command push
	reg                     pend_q;
	reg  [`ISP_CMD_W-1:0]   pend_data_q;
	wire                    buf_in_ready;
	wire [`ISP_CMD_W-1:0]   buf_out;
	// Matches a fixed first and second byte
	function hdr_is(input [7:0] a, input [7:0] b, input [7:0] ea,
		input [7:0] eb);
		hdr_is = (a == ea) && (b == eb);
	endfunction

	isp_pin_sync #(
		.W       (3),
		.RST_VAL (3'b100)
	) u_sync (
		.clk     (ref_clk),
		.rst_n   (rst_n),
		.clk_en  (clk_en),
		.pin_in  ({reset_pin_n, sck_pin, mosi_pin}),
		.level_q (pin_lvl)
	);

	assign sess       = ~pin_lvl[2];
	assign sck_rise   = sess & pin_lvl[1] & ~sck_prev_q;
	assign sck_fall   = sess & ~pin_lvl[1] & sck_prev_q;
	assign rx_d       = {rx_q[6:0], pin_lvl[0]};
	assign byte_done  = sck_rise & (cnt_q[2:0] == 3'h7);
	assign frame_done = byte_done & (cnt_q[4:3] == 2'h3);
	assign clock_source_select_fuses = fuse_low[3:0];

	// Command buffer toward the memory arrays
	isp_buf2 #(
		.W         (`ISP_CMD_W)
	) u_buf (
		.clk       (ref_clk),
		.rst_n     (rst_n),
		.clk_en    (clk_en),
		.in_valid  (pend_q),
		.in_ready  (buf_in_ready),
		.in_data   (pend_data_q),
		.out_valid (nvm_cmd_valid),
		.out_ready (nvm_cmd_ready),
		.out_data  (buf_out)
	);
	assign nvm_cmd_op   = buf_out[`ISP_CMD_OP_LSB +: 2];
	assign nvm_cmd_hi   = buf_out[`ISP_CMD_HI_BIT];
	assign nvm_cmd_addr = buf_out[`ISP_CMD_ADDR_LSB +: `ISP_FADDR_W];
	assign nvm_cmd_data = buf_out[7:0];

	// Bit shifting, byte capture, output shifting
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_prev_q <= 1'b0;
			cnt_q      <= 5'h00;
			rx_q       <= 8'h00;
			b1_q       <= 8'h00;
			b2_q       <= 8'h00;
			b3_q       <= 8'h00;
			tx_q       <= 8'h00;
			miso_o     <= 1'b0;
			miso_oe    <= 1'b0;
		end else if (clk_en) begin
			sck_prev_q <= pin_lvl[1];
			miso_oe    <= sess;
			if (!sess) begin
				cnt_q  <= 5'h00;
				tx_q   <= 8'h00;
				miso_o <= 1'b0;
			end else if (sck_rise) begin
				rx_q  <= rx_d;
				cnt_q <= cnt_q + 5'h01;
				if (byte_done) begin
					tx_q <= rx_d;
					case (cnt_q[4:3])
						2'h0: b1_q <= rx_d;
						2'h1: b2_q <= rx_d;
						2'h2: begin
							b3_q <= rx_d;
							if (hdr_is(b1_q, b2_q, `ISP_B1_RD_LOCK,
								`ISP_B2_RD_ZERO))
								tx_q <= {2'b11, lock_bits};
							if (hdr_is(b1_q, b2_q, `ISP_B1_RD_FUSE,
								`ISP_B2_RD_ZERO))
								tx_q <= fuse_low;
							if (hdr_is(b1_q, b2_q, `ISP_B1_RD_LOCK,
								`ISP_B2_RD_FUSE_HI))
								tx_q <= fuse_high;
						end
						default: ;
					endcase
				end
			end else if (sck_fall) begin
				miso_o <= tx_q[7];
				tx_q   <= {tx_q[6:0], 1'b0};
			end else if (rd_wait_q) begin
				tx_q <= rd_ff_q ? `ISP_ERASED_BYTE : nvm_rd_data;
			end
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			nvm_rd_req   <= 1'b0;
			nvm_rd_space <= `ISP_RD_FLASH;
			nvm_rd_hi    <= 1'b0;
			nvm_rd_addr  <= {`ISP_FADDR_W{1'b0}};
			rd_wait_q    <= 1'b0;
			rd_ff_q      <= 1'b0;
		end else if (clk_en) begin
			rd_wait_q  <= nvm_rd_req;
			nvm_rd_req <= 1'b0;
			if (byte_done && cnt_q[4:3] == 2'h2 && prog_enabled) begin
				if ((b1_q & ~(8'h01 << `ISP_H_BIT)) == `ISP_B1_RD_FLASH
					&& b2_q[7:6] == 2'b00) begin
					nvm_rd_req   <= 1'b1;
					nvm_rd_space <= `ISP_RD_FLASH;
					nvm_rd_hi    <= b1_q[`ISP_H_BIT];
					nvm_rd_addr  <= {b2_q[5:0], rx_d};
					rd_ff_q <= isp_busy && (busy_op_q == `ISP_OP_WR_PAGE)
						&& (busy_addr_q[13:6] == {b2_q[5:0], rx_d[7:6]});
				end
				if (b1_q == `ISP_B1_RD_EE) begin
					nvm_rd_req   <= 1'b1;
					nvm_rd_space <= `ISP_RD_EE;
					nvm_rd_hi    <= 1'b0;
					nvm_rd_addr  <= {4'h0, b2_q[1:0], rx_d};
					rd_ff_q <= isp_busy && (busy_op_q == `ISP_OP_WR_EE)
						&& (busy_addr_q == {4'h0, b2_q[1:0], rx_d});
				end
				if (isp_busy && busy_op_q == `ISP_OP_ERASE)
					rd_ff_q <= 1'b1;
			end
		end
	end

	// Frame execution, busy timer, nonvolatile bits
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prog_enabled <= 1'b0;
			isp_busy     <= 1'b0;
			cmd_refused  <= 1'b0;
			busy_cnt_q   <= {`ISP_BUSY_W{1'b0}};
			busy_op_q    <= `ISP_OP_LOAD;
			busy_addr_q  <= {`ISP_FADDR_W{1'b0}};
			pend_q       <= 1'b0;
			pend_data_q  <= {`ISP_CMD_W{1'b0}};
			lock_bits    <= `ISP_LOCK_RST;
			fuse_low     <= `ISP_FUSE_LO_RST;
			fuse_high    <= `ISP_FUSE_HI_RST;
		end else if (clk_en) begin
			cmd_refused <= 1'b0;
			if (pend_q && buf_in_ready)
				pend_q <= 1'b0;
			if (isp_busy) begin
				busy_cnt_q <= busy_cnt_q - {{(`ISP_BUSY_W-1){1'b0}}, 1'b1};
				if (busy_cnt_q == {{(`ISP_BUSY_W-1){1'b0}}, 1'b1})
					isp_busy <= 1'b0;
			end
			if (!sess) begin
				prog_enabled <= 1'b0;
			end else if (frame_done && !prog_enabled) begin
				if (hdr_is(b1_q, b2_q, `ISP_B1_SPECIAL, `ISP_B2_PROG_EN))
					prog_enabled <= 1'b1;
			end else if (frame_done) begin
				if (b1_q == `ISP_B1_SPECIAL) begin
					if (b2_q[7:5] == `ISP_B2_ERASE) begin
						if (isp_busy || pend_q) begin
							cmd_refused <= 1'b1;
						end else begin
							pend_q      <= 1'b1;
							pend_data_q <= {`ISP_OP_ERASE, 1'b0,
								{`ISP_FADDR_W{1'b0}}, `ISP_ERASED_BYTE};
							lock_bits  <= `ISP_LOCK_RST;
							isp_busy   <= 1'b1;
							busy_op_q  <= `ISP_OP_ERASE;
							busy_cnt_q <= ERASE_WAIT_CYC;
						end
					end else if (b2_q[7:5] == `ISP_B2_WR_LOCK) begin
						lock_bits <= lock_bits & rx_d[`ISP_LOCK_W-1:0];
					end else if (b2_q == `ISP_B2_WR_FUSE_LO) begin
						fuse_low <= rx_d;
					end else if (b2_q == `ISP_B2_WR_FUSE_HI) begin
						fuse_high <= rx_d;
					end
				end else if ((b1_q & ~(8'h01 << `ISP_H_BIT))
					== `ISP_B1_LD_PAGE && b1_q != `ISP_B1_WR_PAGE) begin
					if (isp_busy || pend_q) begin
						cmd_refused <= 1'b1;
					end else begin
						pend_q      <= 1'b1;
						pend_data_q <= {`ISP_OP_LOAD, b1_q[`ISP_H_BIT],
							8'h00, b3_q[5:0], rx_d};
					end
				end else if (b1_q == `ISP_B1_WR_PAGE) begin
					if (isp_busy || pend_q) begin
						cmd_refused <= 1'b1;
					end else begin
						pend_q      <= 1'b1;
						pend_data_q <= {`ISP_OP_WR_PAGE, 1'b0,
							b2_q[5:0], b3_q[7:6], 6'h00, 8'h00};
						isp_busy    <= 1'b1;
						busy_op_q   <= `ISP_OP_WR_PAGE;
						busy_addr_q <= {b2_q[5:0], b3_q[7:6], 6'h00};
						busy_cnt_q  <= FLASH_WAIT_CYC;
					end
				end else if (b1_q == `ISP_B1_WR_EE) begin
					if (isp_busy || pend_q) begin
						cmd_refused <= 1'b1;
					end else begin
						pend_q      <= 1'b1;
						pend_data_q <= {`ISP_OP_WR_EE, 1'b0, 4'h0,
							b2_q[1:0], b3_q, rx_d};
						isp_busy    <= 1'b1;
						busy_op_q   <= `ISP_OP_WR_EE;
						busy_addr_q <= {4'h0, b2_q[1:0], b3_q};
						busy_cnt_q  <= EEPROM_WAIT_CYC;
					end
				end
			end
		end
	end

endmodule

`default_nettype wire

// [sim/isp_port_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module isp_port_assertions #(
	parameter int FLASH_WAIT_CYC = 50
) (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_n,
	// Pins and status
	input wire logic        reset_pin_n,
	input wire logic        miso_o,
	input wire logic        miso_oe,
	input wire logic        prog_enabled,
	input wire logic        isp_busy,
	input wire logic [7:0]  fuse_low,
	input wire logic [3:0]  clock_source_select_fuses,
	// Memory side
	input wire logic        nvm_cmd_valid,
	input wire logic        nvm_cmd_ready,
	input wire logic [1:0]  nvm_cmd_op,
	input wire logic [13:0] nvm_cmd_addr,
	input wire logic [7:0]  nvm_cmd_data,
	input wire logic        nvm_rd_req,
	input wire logic        nvm_rd_space,
	input wire logic [13:0] nvm_rd_addr
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic [19:0] busy_len_q;
	// Length of the current busy spell
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			busy_len_q <= '0;
		else
			busy_len_q <= isp_busy ? busy_len_q + 20'h1 : 20'h0;
	end
	// A stalled word and the word one cycle later
	sequence cmd_stalled;
		nvm_cmd_valid && !nvm_cmd_ready;
	endsequence
	sequence cmd_held;
		nvm_cmd_valid && $stable(nvm_cmd_op) && $stable(nvm_cmd_addr)
			&& $stable(nvm_cmd_data);
	endsequence
	a_miso_quiet: assert property (!miso_oe |-> !miso_o)
		else $error("miso driven outside session");
	a_pin_idle: assert property (
		reset_pin_n [*6] |-> !miso_oe && !prog_enabled)
		else $error("session alive with reset pin high");
	a_rd_single: assert property (
		nvm_rd_req |=> !nvm_rd_req [*8])
		else $error("read request not a lone pulse");
	a_ee_rd_addr: assert property (
		nvm_rd_req && nvm_rd_space |-> nvm_rd_addr[13:10] == 4'h0)
		else $error("eeprom read address too wide");
	a_cmd_held: assert property (cmd_stalled |=> cmd_held)
		else $error("stalled command word changed");
	a_erase_ones: assert property (
		nvm_cmd_valid && nvm_cmd_op == 2'h3 |-> nvm_cmd_data == 8'hff)
		else $error("erase does not carry all ones");
	a_page_align: assert property (
		nvm_cmd_valid && nvm_cmd_op == 2'h1 |-> nvm_cmd_addr[5:0] == 6'h0)
		else $error("page write address not page aligned");
	a_cmd_enabled: assert property (
		$rose(nvm_cmd_valid) |-> prog_enabled)
		else $error("command issued before enable");
	a_busy_min: assert property (
		$fell(isp_busy) |-> busy_len_q >= FLASH_WAIT_CYC)
		else $error("self-timed write too short");
	a_fuse_hold: assert property (
		!prog_enabled |=> $stable(fuse_low)
			&& $stable(clock_source_select_fuses))
		else $error("fuses changed without enable");
endmodule
`default_nettype wire

// [sim/isp_prog_model.sv]
`timescale 1ns/100ps
`default_nettype none
module isp_prog_model (
	// Programming pins
	output logic      reset_pin_n,
	output logic      sck_pin,
	output logic      mosi_pin,
	// Device answer
	input  wire logic miso_o,
	input  wire logic miso_oe
);
	// Line level; a released line rests on its pull-up
	wire miso_w = miso_oe ? miso_o : 1'b1;
	// reset and clock low from power-up
	initial begin
		reset_pin_n = 1'b0;
		sck_pin = 1'b0;
		mosi_pin = 1'b0;
	end
	// all four bytes, 40 ns phases, read late in high
	task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
		for (int i = 31; i >= 0; i--) begin
			mosi_pin = tx[i];
			#40 sck_pin = 1'b1;
			#39 rx[i] = miso_w;
			#1 sck_pin = 1'b0;
		end
		#40 mosi_pin = ~mosi_pin;
	endtask
	// resync by a high pulse on reset
	task automatic resync;
		#200 reset_pin_n = 1'b1;
		#200 reset_pin_n = 1'b0;
		#200;
	endtask
endmodule
`default_nettype wire

// [sim/serial_isp_programming_port_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module serial_isp_programming_port_tb_top;
	logic        ref_clk, rst_n, reset_pin_n, sck_pin, mosi_pin, miso_o;
	logic        miso_oe, nvm_cmd_valid, nvm_cmd_ready, nvm_cmd_hi;
	logic        nvm_rd_req, nvm_rd_space, nvm_rd_hi, prog_enabled;
	logic        isp_busy, cmd_refused, en;
	logic [1:0]  nvm_cmd_op;
	logic [13:0] nvm_cmd_addr, nvm_rd_addr, wd;
	logic [7:0]  nvm_cmd_data, nvm_rd_data, fuse_low, fuse_high, d;
	logic [7:0]  n_cmds, n_ref;
	logic [5:0]  lock_bits;
	logic [3:0]  clock_source_select_fuses;
	logic [31:0] rx;
	logic [9:0]  a;
	logic [7:0]  fl [32768];
	logic [7:0]  ee [1024];
	logic [7:0]  pb [128];
	logic [7:0]  fd [4];
	int          num_errors, tests_run;

	isp_port #(
		.FLASH_WAIT_CYC  (20'd400),
		.EEPROM_WAIT_CYC (20'd600),
		.ERASE_WAIT_CYC  (20'd600)
	) isp_port_inst (
		.ref_clk, .rst_n, .clk_en(en), .reset_pin_n, .sck_pin, .mosi_pin,
		.miso_o, .miso_oe, .nvm_cmd_valid, .nvm_cmd_ready, .nvm_cmd_op,
		.nvm_cmd_hi, .nvm_cmd_addr, .nvm_cmd_data, .nvm_rd_req,
		.nvm_rd_space, .nvm_rd_hi, .nvm_rd_addr, .nvm_rd_data,
		.prog_enabled, .isp_busy, .cmd_refused, .lock_bits, .fuse_low,
		.fuse_high, .clock_source_select_fuses
	);
	isp_prog_model isp_prog_model_inst (
		.reset_pin_n, .sck_pin, .mosi_pin, .miso_o, .miso_oe
	);

	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Memory model: applies taken words, counts words and refusals
	always @(posedge ref_clk) begin
		if (en === 1'b1 && cmd_refused === 1'b1)
			n_ref <= n_ref + 8'h1;
		if (en === 1'b1 && nvm_cmd_valid === 1'b1
			&& nvm_cmd_ready === 1'b1) begin
			n_cmds <= n_cmds + 8'h1;
			case (nvm_cmd_op)
				2'h0: pb[{nvm_cmd_addr[5:0], nvm_cmd_hi}] = nvm_cmd_data;
				2'h1: for (int k = 0; k < 128; k++)
					fl[{nvm_cmd_addr[13:6], k[6:0]}] = pb[k];
				2'h2: ee[nvm_cmd_addr[9:0]] = nvm_cmd_data;
				default: begin
					fl = '{default: 8'hff};
					ee = '{default: 8'hff};
				end
			endcase
		end
	end
	// Read answers and random stalls, off the sampling edge
	always @(negedge ref_clk) begin
		nvm_cmd_ready <= rst_n && ($urandom_range(0, 3) != 0);
		nvm_rd_data <= nvm_rd_space ? ee[nvm_rd_addr[9:0]]
			: fl[{nvm_rd_addr, nvm_rd_hi}];
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task automatic sf(input logic [31:0] w);
		// Pins move on the falling clock edge only
		@(negedge ref_clk);
		isp_prog_model_inst.frame(w, rx);
	endtask
	task automatic rd(input logic [31:0] w, input logic [7:0] exp);
		sf(w);
		chk(rx[7:0], exp);
	endtask
	// Waits for the self-timed write and the buffer to finish
	task automatic wait_idle;
		int n;
		n = 0;
		repeat (8) @(posedge ref_clk);
		while ((isp_busy !== 1'b0 || nvm_cmd_valid !== 1'b0) && n < 9000) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 9000)
			num_errors++;
	endtask
	task automatic end_sim;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Main sequence
	initial begin
		void'($urandom(38));
		rst_n = 1'b0;
		nvm_cmd_ready = 1'b0;
		en = 1'b1;
		nvm_rd_data = 8'h0;
		n_cmds = 8'h0;
		n_ref = 8'h0;
		fl = '{default: 8'h0};
		ee = '{default: 8'h0};
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_n = 1'b1;
		#2003;
		sf(32'hc000_055a);
		sf(32'hac80_0000);
		chk(n_cmds, 8'h0);
		sf(32'hac53_1234);
		chk(rx[15:8], 8'h53);
		chk({7'h0, prog_enabled}, 8'h1);
		sf({8'hac, 3'b100, 5'($urandom), 16'h0});
		wait_idle;
		a = 10'($urandom);
		d = 8'($urandom_range(0, 254));
		sf({8'hc0, 6'h0, a, d});
		rd({8'ha0, 6'h0, a, 8'h0}, 8'hff);
		sf({8'hc0, 6'h0, ~a, 8'h0});
		chk(n_ref, 8'h1);
		// Clock enable low freezes the busy timer
		en = 1'b0;
		repeat (200) @(negedge ref_clk);
		chk({7'h0, isp_busy}, 8'h1);
		en = 1'b1;
		wait_idle;
		rd({8'ha0, 6'h0, a, 8'h0}, d);
		rd({8'ha0, 6'h0, ~a, 8'h0}, 8'hff);
		wd = {8'($urandom), 6'h0};
		for (int w = 0; w < 4; w++) begin
			fd[w] = 8'($urandom);
			sf({4'h4, w[0], 3'h0, 8'h0, 2'b10, {6{w[1]}}, fd[w]});
		end
		sf({8'h4c, 2'b00, wd[13:8], wd[7:0], 8'h0});
		rd({8'h20, 2'b00, wd[13:8], wd[7:0] | 8'h3f, 8'h0}, 8'hff);
		wait_idle;
		for (int w = 0; w < 4; w++)
			rd({4'h2, w[0], 3'h0, 2'b00, wd[13:8],
				wd[7:0] | {2'b0, {6{w[1]}}}, 8'h0}, fd[w]);
		d = 8'($urandom);
		sf({8'hac, 8'he0, 8'h0, 2'b11, d[5:0]});
		chk({2'b11, lock_bits}, {2'b11, d[5:0]});
		rd(32'h5800_0000, {2'b11, d[5:0]});
		sf(32'hace0_00ff);
		rd(32'h5800_0000, {2'b11, d[5:0]});
		sf(32'hac80_0000);
		wait_idle;
		rd(32'h5800_0000, 8'hff);
		for (int f = 0; f < 2; f++) begin
			d = 8'($urandom);
			sf({8'hac, 4'ha, f[0], 3'h0, 8'h0, d});
			chk(f[0] ? fuse_high : {fuse_low[7:4], clock_source_select_fuses}, d);
			rd({4'h5, f[0], 3'h0, 4'h0, f[0], 3'h0, 16'h0}, d);
		end
		isp_prog_model_inst.resync;
		chk({7'h0, prog_enabled}, 8'h0);
		d = n_cmds;
		sf({8'hc0, 6'h0, a, 8'h11});
		repeat (8) @(posedge ref_clk);
		chk(n_cmds, d);
		end_sim;
	end
	// Watchdog
	initial begin
		#400000;
		num_errors++;
		end_sim;
	end
endmodule

bind isp_port isp_port_assertions #(
	.FLASH_WAIT_CYC (FLASH_WAIT_CYC)
) isp_port_assertions_inst (
	.ref_clk, .rst_n, .reset_pin_n, .miso_o, .miso_oe, .prog_enabled,
	.isp_busy, .fuse_low, .clock_source_select_fuses, .nvm_cmd_valid,
	.nvm_cmd_ready, .nvm_cmd_op, .nvm_cmd_addr, .nvm_cmd_data,
	.nvm_rd_req, .nvm_rd_space, .nvm_rd_addr
);
`default_nettype wire
